// ==== design/pmb_pkg.sv ====
// Package of constants for the PCI and Add-On mailbox block
// Operation
// [RL1] Add-On incoming reads come through holding latch
// [RL2] PCI incoming reads come through an interlock
// [RL3] Outgoing write sets flags of enabled bytes
// [RL4] Outgoing box of one side is other's incoming
// [RL5] Outgoing write updates data and both flag views
// [RL6] Incoming read clears flags of bytes read
// [RL7] Flag index is box times four plus byte
// [RL8] Flag registers are read-only, cleared by reads
// [RL9] Flag reset control on each side's control register
// [RL10] Incoming-full and outgoing-empty interrupt sources per side
// [RL11] Each side keeps its own interrupt selections
// [RL12] Raised interrupt stays pending until software clears
// [RL13] PCI events drive INTA, Add-On events drive IRQ
// [RL14] Pin mode: eight data pins, one load clock
// [RL15] Load-clock rising edge raises INTA when selected
// [RL16] Pin byte returned on PCI incoming box 4 byte 3
// [RL17] Byte-wide boot: byte reads zero, no pin interrupt
// [RL18] Writing one to reset bit clears all flags
// [RL19] Latch pins on rising edge, ignore until cleared
// [RL20] Overwrite full boxes, reread empty, never refuse
package pmb_pkg;
  localparam int         PMB_AW          = 6;
  localparam int         PMB_DW          = 32;
  localparam int         PMB_BOXES       = 4;
  localparam logic [5:0] PMB_OFS_OUT     = 6'h00;
  localparam logic [5:0] PMB_OFS_IN      = 6'h10;
  localparam logic [5:0] PMB_OFS_FLAGS   = 6'h20;
  localparam logic [5:0] PMB_OFS_CTRL    = 6'h24;
  localparam logic [5:0] PMB_OFS_IRQ     = 6'h28;
  localparam int         PMB_FLAG_RST    = 0;
  localparam int         PMB_OBYTE_LSB   = 0;
  localparam int         PMB_OBOX_LSB    = 2;
  localparam int         PMB_OEN         = 4;
  localparam int         PMB_IBYTE_LSB   = 8;
  localparam int         PMB_IBOX_LSB    = 10;
  localparam int         PMB_IEN         = 12;
  localparam int         PMB_CFG_W       = 13;
  localparam logic [12:0] PMB_CFG_MASK   = 13'h1f1f;
  localparam int         PMB_PEND_LSB    = 16;
  localparam int         PMB_PEND_OUT    = 0;
  localparam int         PMB_PEND_IN     = 1;
  localparam logic [1:0] PMB_DIRECT_BOX  = 2'h3;
  localparam logic [3:0] PMB_DIRECT_BE   = 4'h8;
  localparam int         PMB_DIRECT_FLAG = 31;
  localparam logic [1:0] PMB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PMB_RESP_SLVERR = 2'h2;
endpackage

// ==== design/pmb_mem_if.sv ====
// Interface between the mailbox core and one mailbox storage bank
`timescale 1ns/1ps
interface pmb_mem_if;
  import pmb_pkg::*;
  logic              we;
  logic [1:0]        waddr;
  logic [3:0]        wbe;
  logic [PMB_DW-1:0] wdata;
  logic              re_a;
  logic [1:0]        raddr_a;
  logic [PMB_DW-1:0] rdata_a;
  logic              re_b;
  logic [1:0]        raddr_b;
  logic [PMB_DW-1:0] rdata_b;
  modport mem  (input we, waddr, wbe, wdata, re_a, raddr_a, re_b, raddr_b,
                output rdata_a, rdata_b);
  modport user (output we, waddr, wbe, wdata, re_a, raddr_a, re_b, raddr_b,
                input rdata_a, rdata_b);
endinterface

// ==== design/pmb_box_mem.sv ====
// Four-word mailbox bank with byte writes and two latched read ports
`timescale 1ns/1ps
module pmb_box_mem
  import pmb_pkg::*;
#(
  parameter int DEPTH = PMB_BOXES
) (
  input wire logic CLK,
  input wire logic NRST,
  pmb_mem_if.mem   port
);
  // Each byte lane is a bank of its own, so every store has one writer
  wire [PMB_DW-1:0] rd_a_w;
  wire [PMB_DW-1:0] rd_b_w;

  // Read data are latched, so a write in the same cycle cannot tear them
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      port.rdata_a <= '0;
    end else if (port.re_a) begin
      port.rdata_a <= rd_a_w; // RL1 RL2
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      port.rdata_b <= '0;
    end else if (port.re_b) begin
      port.rdata_b <= rd_b_w;
    end
  end

  for (genvar b = 0; b < PMB_DW / 8; b++) begin : g_byte
    logic [7:0] bank_q [DEPTH];
    always_ff @(posedge CLK) begin
      if (port.we && port.wbe[b]) begin
        bank_q[port.waddr] <= port.wdata[8*b +: 8]; // RL20
      end
    end
    assign rd_a_w[8*b +: 8] = bank_q[port.raddr_a];
    assign rd_b_w[8*b +: 8] = bank_q[port.raddr_b];
  end
endmodule

// ==== design/pmb_mailbox.sv ====
// Mailbox block: AXI4-Lite PCI side, Add-On local bus, flags, interrupts
`timescale 1ns/1ps
module pmb_mailbox
  import pmb_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic [PMB_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [PMB_DW-1:0] S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [PMB_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [PMB_DW-1:0]      S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [PMB_AW-1:0] AO_ADDR,
  input  wire logic              AO_WR,
  input  wire logic              AO_RD,
  input  wire logic [3:0]        AO_BE,
  input  wire logic [PMB_DW-1:0] AO_WDATA,
  output logic [PMB_DW-1:0]      AO_RDATA,
  output logic                   AO_RVALID,
  input  wire logic              BOOT_BYTE_WIDE,
  input  wire logic [7:0]        DIRECT_BOX_DATA_IN,
  input  wire logic              DIRECT_BOX_LOAD_CLK,
  output logic                   INTA_N,
  output logic                   IRQ_N
);
  function automatic logic is_out(input logic [PMB_AW-1:0] a);
    return a >= PMB_OFS_OUT && a < PMB_OFS_IN && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_in(input logic [PMB_AW-1:0] a);
    return a >= PMB_OFS_IN && a < PMB_OFS_FLAGS && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_mapped(input logic [PMB_AW-1:0] a);
    return a <= PMB_OFS_IRQ && a[1:0] == 2'h0;
  endfunction

  // Flag index {direction, box, byte}: direction 1 is Add-On to PCI
  function automatic logic [4:0] flag_idx(input logic dir,
                                          input logic [1:0] box,
                                          input logic [1:0] bsel);
    return {dir, box, bsel}; // RL7
  endfunction

  function automatic logic [4:0] sel_idx(input logic [PMB_CFG_W-1:0] cfg,
                                         input logic in_cond,
                                         input logic dir);
    if (in_cond) begin
      return flag_idx(dir, cfg[PMB_IBOX_LSB +: 2], cfg[PMB_IBYTE_LSB +: 2]);
    end
    return flag_idx(dir, cfg[PMB_OBOX_LSB +: 2], cfg[PMB_OBYTE_LSB +: 2]);
  endfunction

  function automatic logic [PMB_DW-1:0] irq_word(
      input logic [PMB_CFG_W-1:0] cfg, input logic [1:0] pend);
    logic [PMB_DW-1:0] w;
    w = '0;
    w[PMB_CFG_W-1:0] = cfg;
    w[PMB_PEND_LSB +: 2] = pend;
    return w;
  endfunction

  pmb_mem_if p2a ();
  pmb_mem_if a2p ();

  logic              aw_full_q;
  logic [PMB_AW-1:0] awaddr_q;
  logic              w_full_q;
  logic [PMB_DW-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rd_busy_q;
  logic [PMB_AW-1:0] rd_addr_q;
  logic              rvalid_q;
  logic [PMB_DW-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              ao_busy_q;
  logic [PMB_AW-1:0] ao_addr_q;
  logic [PMB_DW-1:0] ao_rdata_q;
  logic [PMB_DW-1:0] flags_q;
  logic [PMB_DW-1:0] flags_d;
  logic [PMB_DW-1:0] set_v;
  logic [PMB_DW-1:0] clr_v;
  logic [PMB_DW-1:0] rise;
  logic [PMB_DW-1:0] fall;
  logic [PMB_CFG_W-1:0] pci_cfg_q;
  logic [PMB_CFG_W-1:0] ao_cfg_q;
  logic [1:0]        pci_pend_q;
  logic [1:0]        ao_pend_q;
  logic [1:0]        pci_ev;
  logic [1:0]        ao_ev;
  logic [1:0]        pci_clr;
  logic [1:0]        ao_clr;
  logic              clk_s1_q;
  logic              clk_s2_q;
  logic              clk_s3_q;
  logic [7:0]        dat_s1_q;
  logic [7:0]        dat_s2_q;
  logic              wide_s1_q;
  logic              wide_s2_q;
  logic [7:0]        direct_byte_q;
  logic              wr_go;
  logic              rd_acc;
  logic              p_wr_out;
  logic              p_rd_in;
  logic              a_wr_out;
  logic              a_rd_in;
  logic              glob_clr;
  logic              dir_edge;
  logic              dir_take;
  logic [3:0]        ao_be_m;

  // Box 4 byte 3 of the Add-On to PCI bank comes from pins or reads zero
  function automatic logic [PMB_DW-1:0] fix_in(input logic [PMB_DW-1:0] w,
                                               input logic [1:0] box,
                                               input logic wide,
                                               input logic [7:0] pin);
    logic [PMB_DW-1:0] r;
    r = w;
    if (box == PMB_DIRECT_BOX) begin
      r[PMB_DW-1 -: 8] = wide ? 8'h00 : pin; // RL16 RL17
    end
    return r;
  endfunction

  pmb_box_mem #(.DEPTH(PMB_BOXES)) u_p2a (
    .CLK  (CLK),
    .NRST (NRST),
    .port (p2a.mem)
  );

  pmb_box_mem #(.DEPTH(PMB_BOXES)) u_a2p (
    .CLK  (CLK),
    .NRST (NRST),
    .port (a2p.mem)
  );

  // AXI4-Lite write: address and data taken in either order
  assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_full_q && !bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign wr_go         = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_q <= 1'b1;
      wdata_q  <= S_AXI_WDATA;
      wstrb_q  <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  // Writes to full boxes or read-only words complete normally
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PMB_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1; // RL20
      bresp_q  <= is_mapped(awaddr_q) ? PMB_RESP_OKAY : PMB_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // AXI4-Lite read: one stage for the latched bank read, then data
  assign S_AXI_ARREADY = !rd_busy_q && !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign rd_acc        = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rd_busy_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_busy_q <= rd_acc;
      if (rd_acc) begin
        rd_addr_q <= S_AXI_ARADDR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= PMB_RESP_OKAY;
    end else if (rd_busy_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(rd_addr_q) ? PMB_RESP_OKAY : PMB_RESP_SLVERR;
      if (is_out(rd_addr_q)) begin
        rdata_q <= p2a.rdata_b;
      end else if (is_in(rd_addr_q)) begin
        rdata_q <= fix_in(a2p.rdata_a, rd_addr_q[3:2], wide_s2_q,
                          direct_byte_q); // RL2 RL16
      end else if (rd_addr_q == PMB_OFS_FLAGS) begin
        rdata_q <= flags_q;
      end else if (rd_addr_q == PMB_OFS_IRQ) begin
        rdata_q <= irq_word(pci_cfg_q, pci_pend_q);
      end else begin
        rdata_q <= '0; // RL18
      end
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // Add-On local bus: reads answer two cycles after the strobe
  assign AO_RDATA  = ao_rdata_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ao_busy_q <= 1'b0;
      ao_addr_q <= '0;
      AO_RVALID <= 1'b0;
    end else begin
      ao_busy_q <= AO_RD;
      AO_RVALID <= ao_busy_q;
      if (AO_RD) begin
        ao_addr_q <= AO_ADDR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ao_rdata_q <= '0;
    end else if (ao_busy_q) begin
      if (is_in(ao_addr_q)) begin
        ao_rdata_q <= p2a.rdata_a; // RL1
      end else if (is_out(ao_addr_q)) begin
        ao_rdata_q <= fix_in(a2p.rdata_b, ao_addr_q[3:2], wide_s2_q,
                             direct_byte_q);
      end else if (ao_addr_q == PMB_OFS_FLAGS) begin
        ao_rdata_q <= flags_q;
      end else if (ao_addr_q == PMB_OFS_IRQ) begin
        ao_rdata_q <= irq_word(ao_cfg_q, ao_pend_q);
      end else begin
        ao_rdata_q <= '0;
      end
    end
  end

  // Bank wiring: each bank is one side's outgoing and the other's incoming
  assign p_wr_out = wr_go && is_out(awaddr_q);
  assign p_rd_in  = rd_acc && is_in(S_AXI_ARADDR);
  assign a_wr_out = AO_WR && is_out(AO_ADDR);
  assign a_rd_in  = AO_RD && is_in(AO_ADDR);
  // The pin byte never takes Add-On bus data
  assign ao_be_m  = (AO_ADDR[3:2] == PMB_DIRECT_BOX) ?
                    (AO_BE & ~PMB_DIRECT_BE) : AO_BE; // RL14 RL17

  always_comb begin
    p2a.we      = p_wr_out; // RL4 RL5
    p2a.waddr   = awaddr_q[3:2];
    p2a.wbe     = wstrb_q;
    p2a.wdata   = wdata_q;
    p2a.re_a    = AO_RD;
    p2a.raddr_a = AO_ADDR[3:2];
    p2a.re_b    = rd_acc;
    p2a.raddr_b = S_AXI_ARADDR[3:2];
    a2p.we      = a_wr_out; // RL4 RL5
    a2p.waddr   = AO_ADDR[3:2];
    a2p.wbe     = ao_be_m;
    a2p.wdata   = AO_WDATA;
    a2p.re_a    = rd_acc;
    a2p.raddr_a = S_AXI_ARADDR[3:2];
    a2p.re_b    = AO_RD;
    a2p.raddr_b = AO_ADDR[3:2];
  end

  // Direct pins pass two flops; the edge detector compares the second with a third flop
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      clk_s1_q  <= 1'b1;
      clk_s2_q  <= 1'b1;
      clk_s3_q  <= 1'b1;
      dat_s1_q  <= 8'h00;
      dat_s2_q  <= 8'h00;
      wide_s1_q <= 1'b0;
      wide_s2_q <= 1'b0;
    end else begin
      clk_s1_q  <= DIRECT_BOX_LOAD_CLK;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      dat_s1_q  <= DIRECT_BOX_DATA_IN;
      dat_s2_q  <= dat_s1_q;
      wide_s1_q <= BOOT_BYTE_WIDE;
      wide_s2_q <= wide_s1_q;
    end
  end

  assign dir_edge = clk_s2_q && !clk_s3_q; // RL15
  // Edges are ignored while the PCI incoming interrupt is still pending
  assign dir_take = dir_edge && !wide_s2_q &&
                    !pci_pend_q[PMB_PEND_IN]; // RL19 RL17

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      direct_byte_q <= 8'h00;
    end else if (dir_take) begin
      direct_byte_q <= dat_s2_q; // RL14 RL19
    end
  end

  // Flags: a set in the same cycle as a clear or a global reset wins
  assign glob_clr = (wr_go && awaddr_q == PMB_OFS_CTRL &&
                     wdata_q[PMB_FLAG_RST]) ||
                    (AO_WR && AO_ADDR == PMB_OFS_CTRL &&
                     AO_WDATA[PMB_FLAG_RST]); // RL9 RL18

  always_comb begin
    set_v = '0;
    clr_v = '0;
    if (p_wr_out) begin
      set_v[flag_idx(1'b0, awaddr_q[3:2], 2'h0) +: 4] = wstrb_q; // RL3
    end
    if (a_wr_out) begin
      set_v[flag_idx(1'b1, AO_ADDR[3:2], 2'h0) +: 4] = ao_be_m; // RL3
    end
    if (dir_take) begin
      set_v[PMB_DIRECT_FLAG] = 1'b1; // RL15
    end
    if (p_rd_in) begin
      clr_v[flag_idx(1'b1, S_AXI_ARADDR[3:2], 2'h0) +: 4] = 4'hf; // RL6
    end
    if (a_rd_in) begin
      clr_v[flag_idx(1'b0, AO_ADDR[3:2], 2'h0) +: 4] = AO_BE; // RL6
    end
    flags_d = glob_clr ? set_v : ((flags_q & ~clr_v) | set_v); // RL18
  end

  // One flag vector serves both status views; writes to the flag word never reach it
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d; // RL4 RL8
    end
  end

  assign rise = flags_d & ~flags_q;
  assign fall = flags_q & ~flags_d;

  // Interrupt selections, held apart for each side
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pci_cfg_q <= '0;
    end else if (wr_go && awaddr_q == PMB_OFS_IRQ) begin
      pci_cfg_q <= wdata_q[PMB_CFG_W-1:0] & PMB_CFG_MASK; // RL11
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ao_cfg_q <= '0;
    end else if (AO_WR && AO_ADDR == PMB_OFS_IRQ) begin
      ao_cfg_q <= AO_WDATA[PMB_CFG_W-1:0] & PMB_CFG_MASK; // RL11
    end
  end

  always_comb begin
    // A pin edge interrupts even if the pin byte was never read empty
    pci_ev[PMB_PEND_IN]  = pci_cfg_q[PMB_IEN] &&
                           (rise[sel_idx(pci_cfg_q, 1'b1, 1'b1)] ||
                            (dir_take && sel_idx(pci_cfg_q, 1'b1, 1'b1) ==
                             5'(PMB_DIRECT_FLAG))); // RL10 RL15
    pci_ev[PMB_PEND_OUT] = pci_cfg_q[PMB_OEN] &&
                           fall[sel_idx(pci_cfg_q, 1'b0, 1'b0)]; // RL10
    ao_ev[PMB_PEND_IN]   = ao_cfg_q[PMB_IEN] &&
                           rise[sel_idx(ao_cfg_q, 1'b1, 1'b0)]; // RL10
    ao_ev[PMB_PEND_OUT]  = ao_cfg_q[PMB_OEN] &&
                           fall[sel_idx(ao_cfg_q, 1'b0, 1'b1)]; // RL10
    pci_clr = (wr_go && awaddr_q == PMB_OFS_IRQ) ?
              wdata_q[PMB_PEND_LSB +: 2] : 2'h0;
    ao_clr  = (AO_WR && AO_ADDR == PMB_OFS_IRQ) ?
              AO_WDATA[PMB_PEND_LSB +: 2] : 2'h0;
  end

  // Pending bits stay until software writes one to them
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pci_pend_q <= 2'h0;
      ao_pend_q  <= 2'h0;
    end else begin
      pci_pend_q <= (pci_pend_q & ~pci_clr) | pci_ev; // RL12
      ao_pend_q  <= (ao_pend_q & ~ao_clr) | ao_ev; // RL12
    end
  end

  assign INTA_N = ~|pci_pend_q; // RL13
  assign IRQ_N  = ~|ao_pend_q; // RL13

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_pci_fetch;
    rd_acc ##1 rd_busy_q;
  endsequence

  a_flag_set_be: assert property ( // RL3
    p_wr_out |=> (flags_q[flag_idx(1'b0, $past(awaddr_q[3:2]), 2'h0) +: 4]
                  & $past(wstrb_q)) == $past(wstrb_q))
    else $error("write did not set enabled byte flags");
  a_glob_clear: assert property ( // RL18
    (glob_clr && set_v == '0) |=> flags_q == '0)
    else $error("global flag reset left flags set");
  a_ao_rd_clear: assert property ( // RL6
    (a_rd_in && !p_wr_out && !glob_clr) |=>
      (flags_q[flag_idx(1'b0, $past(AO_ADDR[3:2]), 2'h0) +: 4]
       & $past(AO_BE)) == 4'h0)
    else $error("Add-On read did not clear its byte flags");
  a_rdata_hold: assert property ( // RL2
    (S_AXI_RVALID && !S_AXI_RREADY) |=> $stable(S_AXI_RDATA))
    else $error("read data changed while held");
  a_ao_latch: assert property ( // RL1
    (!AO_RD && ao_busy_q) |=> $stable(p2a.rdata_a))
    else $error("Add-On incoming latch changed without a read");
  a_irq_sticky: assert property ( // RL12
    (pci_pend_q[PMB_PEND_IN] && !pci_clr[PMB_PEND_IN]) |=>
      pci_pend_q[PMB_PEND_IN] ##0 !INTA_N)
    else $error("PCI interrupt withdrawn without clear");
  a_pin_irq: assert property ( // RL15
    (dir_take && pci_cfg_q[PMB_IEN] &&
     sel_idx(pci_cfg_q, 1'b1, 1'b1) == 5'(PMB_DIRECT_FLAG)) |=> !INTA_N)
    else $error("load clock edge did not raise INTA");
  a_pin_ignore: assert property ( // RL19
    (pci_pend_q[PMB_PEND_IN] && dir_edge) |=> $stable(direct_byte_q))
    else $error("pin byte latched while interrupt pending");
  a_wide_zero: assert property ( // RL17
    (s_pci_fetch ##0 (wide_s2_q && is_in(rd_addr_q) &&
     rd_addr_q[3:2] == PMB_DIRECT_BOX)) |=> S_AXI_RDATA[31:24] == 8'h00)
    else $error("box 4 byte 3 not zero in byte-wide mode");
endmodule

// ==== tb/pmb_addon_pins.sv ====
// Add-On hardware model driving the direct mailbox pins
`timescale 1ns/1ps
module pmb_addon_pins (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] val,
  output logic            load_clk,
  output logic [7:0]      data
);
  initial begin
    load_clk = 1'b1;
    data     = 8'h00;
  end
  // Data held steady well around the rising edge of the load clock
  always begin
    @(posedge go);
    @(posedge clk);
    data <= val;
    repeat (3) @(posedge clk);
    load_clk <= 1'b0;
    repeat (3) @(posedge clk);
    load_clk <= 1'b1;
    repeat (3) @(posedge clk);
    // Hold over: stale pins must not be seen as the latched byte
    data <= ~val;
  end
endmodule

// ==== tb/pmb_mailbox_tb.sv ====
// Self-checking bench for the mailbox block
`timescale 1ns/1ps
module pmb_mailbox_tb import pmb_pkg::*;;
  logic        clk, nrst, awv, wv, arv, aow, aor, wide, lgo, pclk;
  logic        awr, wr, bv, arr, rv, aorv, inta_n, irq_n;
  logic        bry, rry, rdly;
  logic [5:0]  awa, ara, aoa;
  logic [31:0] wd, aod, rd, rdt, aord;
  logic [3:0]  ws, aobe;
  logic [7:0]  pv, pd;
  logic [1:0]  br, rr, lbr;
  int          n_mismatch, cmp_count;

  pmb_mailbox pmb_mailbox_i (
    .CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .AO_ADDR(aoa), .AO_WR(aow), .AO_RD(aor), .AO_BE(aobe),
    .AO_WDATA(aod), .AO_RDATA(aord), .AO_RVALID(aorv),
    .BOOT_BYTE_WIDE(wide), .DIRECT_BOX_DATA_IN(pd),
    .DIRECT_BOX_LOAD_CLK(pclk), .INTA_N(inta_n), .IRQ_N(irq_n));

  pmb_addon_pins pmb_addon_pins_i (.clk(clk), .go(lgo), .val(pv),
    .load_clk(pclk), .data(pd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    awa <= a;
    wd  <= d;
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    lbr = br;
  endtask

  task automatic axr(input logic [5:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= !rdly;
    // A slow master raises rready only once it has seen rvalid
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && !rry) rry <= 1'b1;
    end while (!(rv && rry));
    rd  = rdt;
    lbr = rr;
  endtask

  // Add-On bus has no ready: strobe one cycle, read waits for rvalid
  task automatic aot(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    aoa  <= a;
    aod  <= d;
    aobe <= b;
    aow  <= w;
    aor  <= !w;
    @(posedge clk);
    aow <= 1'b0;
    aor <= 1'b0;
    do @(posedge clk); while (!w && !aorv);
    rd = aord;
  endtask

  task automatic pin(input logic [7:0] v);
    pv  <= v;
    lgo <= 1'b1;
    @(posedge clk);
    lgo <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {nrst, awv, wv, arv, aow, aor, wide, lgo} = 8'h00;
    {awa, ara, aoa, wd, aod, ws, aobe, pv} = '0;
    {bry, rry, rdly} = 3'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    axw(6'h04, 32'h11223344, 4'h3);
    axr(PMB_OFS_FLAGS);
    chk("pci flags", rd, 32'h30);
    aot(1'b0, PMB_OFS_FLAGS, 0, 4'hf);
    chk("addon flags", rd, 32'h30);
    aot(1'b0, 6'h14, 0, 4'h3);
    chk("addon in2", rd & 32'hffff, 32'h3344);
    axr(PMB_OFS_FLAGS);
    chk("flags read", rd, 32'h0);
    $display("test 1 done");
    aot(1'b1, PMB_OFS_OUT, 32'hcafe0001, 4'hf);
    aot(1'b1, PMB_OFS_OUT, 32'h000000aa, 4'h1);
    axw(PMB_OFS_FLAGS, 32'hffffffff, 4'hf);
    axr(PMB_OFS_FLAGS);
    chk("flags ro", rd, 32'h000f0000);
    axr(PMB_OFS_IN);
    chk("pci in1", rd, 32'hcafe00aa);
    axr(PMB_OFS_FLAGS);
    chk("flags clr", rd, 32'h0);
    rdly = 1'b1;
    axr(PMB_OFS_IN);
    rdly = 1'b0;
    chk("reread", rd, 32'hcafe00aa);
    axw(6'h2c, 32'h1, 4'hf);
    chk("unmapped", lbr, PMB_RESP_SLVERR);
    axr(6'h2c);
    chk("rd unmapped", lbr, PMB_RESP_SLVERR);
    $display("test 2 done");
    axw(6'h08, 32'h1, 4'hf);
    aot(1'b1, 6'h08, 32'h2, 4'hf);
    axw(PMB_OFS_CTRL, 32'h0, 4'hf);
    axr(PMB_OFS_FLAGS);
    chk("zero rst", rd, 32'h0f000f00);
    axw(PMB_OFS_CTRL, 32'h1, 4'hf);
    axr(PMB_OFS_FLAGS);
    chk("pci rst", rd, 32'h0);
    axr(PMB_OFS_CTRL);
    chk("rst wo", rd, 32'h0);
    aot(1'b1, 6'h08, 32'h3, 4'h1);
    aot(1'b1, PMB_OFS_CTRL, 32'h1, 4'hf);
    axr(PMB_OFS_FLAGS);
    chk("ao rst", rd, 32'h0);
    $display("test 3 done");
    axw(PMB_OFS_IRQ, 32'h1000, 4'hf);
    aot(1'b1, PMB_OFS_IRQ, 32'h10, 4'hf);
    aot(1'b1, PMB_OFS_OUT, 32'h5, 4'h1);
    repeat (3) @(posedge clk);
    chk("inta full", inta_n, 32'h0);
    chk("irq sep", irq_n, 32'h1);
    axr(PMB_OFS_IN);
    repeat (3) @(posedge clk);
    chk("irq empty", irq_n, 32'h0);
    chk("inta held", inta_n, 32'h0);
    axw(PMB_OFS_IRQ, 32'h21000, 4'hf);
    aot(1'b1, PMB_OFS_IRQ, 32'h10010, 4'hf);
    repeat (2) @(posedge clk);
    chk("inta clr", inta_n, 32'h1);
    chk("irq clr", irq_n, 32'h1);
    $display("test 4 done");
    aot(1'b1, 6'h0c, 32'h00112233, 4'h7);
    axw(PMB_OFS_IRQ, 32'h1f00, 4'hf);
    pin(8'ha5);
    chk("pin inta", inta_n, 32'h0);
    axr(PMB_OFS_FLAGS);
    chk("pin flag", rd, 32'hf0000000);
    pin(8'h3c);
    axr(6'h1c);
    chk("pin byte", rd, 32'ha5112233);
    axw(PMB_OFS_IRQ, 32'h21f00, 4'hf);
    wide <= 1'b1;
    repeat (4) @(posedge clk);
    pin(8'h77);
    chk("wide inta", inta_n, 32'h1);
    axr(6'h1c);
    chk("wide byte", rd & 32'hff000000, 32'h0);
    $display("test 5 done");
    report_and_stop();
  end
endmodule
